// *** logic/cist_timing.sv ***
// Contract
// - total states of an instruction is the sum over cycle kinds of count times state length.
// - each instruction splits into fetch, branch address, stack, byte, word and internal cycles with fixed counts.
// - a fetch takes 2 states on-chip, 6 from an 8-bit supporting module and 3 from a 16-bit one.
// - an external fetch takes 4, 6+2m, 2 or 3+m states for 8-bit 2-state, 8-bit 3-state, 16-bit 2-state, 16-bit 3-state.
// - a byte access takes 3 states on an 8-bit supporting module, and 2 or 3+m on an 8-bit external device.
// - a word access takes 6 states on an 8-bit supporting module, and 4 or 6+2m on an 8-bit external device.
// - an internal operation always takes one state.
// - add takes one fetch for register forms and byte immediate, two for word immediate, three for long immediate.
// - add small constant, add with carry and and to condition codes take one fetch and nothing else.
// - bit and to carry takes one fetch on a register, two fetches and one byte access on memory.
// - every 8-bit displacement conditional branch takes exactly two fetches and nothing else.
`timescale 1ns/10ps
`default_nettype none

module cist_timing (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic start,
   input wire cist_pkg::cist_instr_t instr,
   input wire cist_pkg::cist_cfg_t cfg,
   output logic ready,
   output logic busy,
   output logic done,
   output logic cycle_start,
   output cist_pkg::cist_kind_t cur_kind,
   output logic [cist_pkg::CIST_TOT_W-1:0] total_states,
   output logic [cist_pkg::CIST_TOT_W-1:0] elapsed_states
);
   import cist_pkg::*;

   typedef enum logic {CIST_S_IDLE, CIST_S_RUN} cist_phase_t;

   typedef struct packed {
      cist_phase_t phase;
      cist_kind_t kind;
      logic [CIST_CNT_W-1:0] cyc_left;
      logic [CIST_LEN_W-1:0] st_left;
      cist_counts_t counts;
      logic [CIST_KINDS-1:0][CIST_LEN_W-1:0] lens;
      logic [CIST_TOT_W-1:0] total;
      logic [CIST_TOT_W-1:0] elapsed;
      logic done;
      logic cyc_start;
   } cist_state_t;

   cist_state_t st_ff;
   cist_state_t nxt_st;
   cist_counts_t dec_counts;
   cist_tgt_t kind_tgt [CIST_KINDS];
   logic [CIST_LEN_W-1:0] kind_len [CIST_KINDS];
   logic [CIST_TOT_W-1:0] sum_states;
   logic found;
   cist_kind_t nxt_kind;

   ////////////////////////////////////////////////////////////////////////
   // decode: cycle counts per instruction form, blanks stay zero
   always_comb begin
      dec_counts = '0;
      dec_counts[CIST_K_FETCH] = 2'h1;
      case (instr)
         CIST_I_ADD_W_IMM: dec_counts[CIST_K_FETCH] = 2'h2;
         CIST_I_ADD_L_IMM: dec_counts[CIST_K_FETCH] = 2'h3;
         CIST_I_AND_W_IMM: dec_counts[CIST_K_FETCH] = 2'h2;
         CIST_I_AND_L_IMM: dec_counts[CIST_K_FETCH] = 2'h3;
         CIST_I_AND_L_REG: dec_counts[CIST_K_FETCH] = 2'h2;
         CIST_I_BIT_AND_CARRY_IND,
         CIST_I_BIT_AND_CARRY_ABS8: begin
            dec_counts[CIST_K_FETCH] = 2'h2;
            dec_counts[CIST_K_BYTE] = 2'h1;
         end
         CIST_I_BRANCH_COND_D8: dec_counts[CIST_K_FETCH] = 2'h2;
         // add small constant, add with carry, and to condition codes: one fetch
         CIST_I_ADD_SMALL_CONSTANT,
         CIST_I_ADD_WITH_CARRY_IMM,
         CIST_I_ADD_WITH_CARRY_REG,
         CIST_I_AND_TO_CONDITION_CODES: dec_counts[CIST_K_FETCH] = 2'h1;
         default: dec_counts[CIST_K_FETCH] = 2'h1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state length of every kind under the requested configuration
   always_comb begin
      kind_tgt[CIST_K_FETCH] = cfg.fetch_tgt;
      kind_tgt[CIST_K_BRANCH_ADDR] = cfg.data_tgt;
      kind_tgt[CIST_K_STACK] = cfg.stack_tgt;
      kind_tgt[CIST_K_BYTE] = cfg.data_tgt;
      kind_tgt[CIST_K_WORD] = cfg.data_tgt;
      kind_tgt[CIST_K_INTERNAL] = cfg.data_tgt;
   end

   genvar gk;
   generate
      for (gk = 0; gk < CIST_KINDS; gk++) begin : g_len
         cist_len u_len (
            .kind(cist_kind_t'(gk)),
            .tgt(kind_tgt[gk]),
            .wait_m(cfg.wait_m),
            .len(kind_len[gk])
         );
      end
   endgenerate

   // total is only as good as the counts and lengths it is built from
   always_comb begin
      sum_states = '0;
      for (int k = 0; k < CIST_KINDS; k++) begin
         // widen both factors first: three 36-state fetches overflow a 6-bit product
         sum_states = sum_states + CIST_TOT_W'(dec_counts[k]) * CIST_TOT_W'(kind_len[k]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next kind with a nonzero count after the current one
   always_comb begin
      found = 1'b0;
      nxt_kind = st_ff.kind;
      for (int k = CIST_KINDS - 1; k >= 0; k--) begin
         if (k > int'(st_ff.kind) && st_ff.counts[k] != '0) begin
            found = 1'b1;
            nxt_kind = cist_kind_t'(k);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // walker: one clock per state, kinds in order, zero kinds skipped
   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.cyc_start = 1'b0;
      case (st_ff.phase)
         CIST_S_IDLE: begin
            if (start) begin
               nxt_st.phase = CIST_S_RUN;
               nxt_st.counts = dec_counts;
               for (int k = 0; k < CIST_KINDS; k++) begin
                  nxt_st.lens[k] = kind_len[k];
               end
               nxt_st.total = sum_states;
               nxt_st.elapsed = '0;
               // every form has at least one fetch, so the walk opens there
               nxt_st.kind = CIST_K_FETCH;
               nxt_st.cyc_left = dec_counts[CIST_K_FETCH];
               nxt_st.st_left = kind_len[CIST_K_FETCH];
               nxt_st.cyc_start = 1'b1;
            end
         end
         CIST_S_RUN: begin
            nxt_st.elapsed = st_ff.elapsed + 10'h001;
            if (st_ff.st_left > 6'h01) begin
               nxt_st.st_left = st_ff.st_left - 6'h01;
            end else if (st_ff.cyc_left > 2'h1) begin
               nxt_st.cyc_left = st_ff.cyc_left - 2'h1;
               nxt_st.st_left = st_ff.lens[st_ff.kind];
               nxt_st.cyc_start = 1'b1;
            end else if (found) begin
               nxt_st.kind = nxt_kind;
               nxt_st.cyc_left = st_ff.counts[nxt_kind];
               nxt_st.st_left = st_ff.lens[nxt_kind];
               nxt_st.cyc_start = 1'b1;
            end else begin
               nxt_st.phase = CIST_S_IDLE;
               nxt_st.done = 1'b1;
            end
         end
         default: nxt_st.phase = CIST_S_IDLE;
      endcase
   end

   // one register for all state, synchronous reset
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.phase <= CIST_S_IDLE;
         st_ff.kind <= CIST_K_FETCH;
         st_ff.total <= CIST_TOT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign ready = (st_ff.phase == CIST_S_IDLE);
   assign busy = (st_ff.phase == CIST_S_RUN);
   assign done = st_ff.done;
   assign cycle_start = st_ff.cyc_start;
   assign cur_kind = st_ff.kind;
   assign total_states = st_ff.total;
   assign elapsed_states = st_ff.elapsed;

endmodule : cist_timing

`default_nettype wire

// *** logic/cist_pkg.sv ***
package cist_pkg;

   // widths
   localparam int CIST_KINDS = 6;
   localparam int CIST_LEN_W = 6;
   localparam int CIST_CNT_W = 2;
   localparam int CIST_WAIT_W = 4;
   localparam int CIST_TOT_W = 10;

   // cycle kinds, in execution order
   typedef enum logic [2:0] {
      CIST_K_FETCH,
      CIST_K_BRANCH_ADDR,
      CIST_K_STACK,
      CIST_K_BYTE,
      CIST_K_WORD,
      CIST_K_INTERNAL
   } cist_kind_t;

   // what a cycle is aimed at
   typedef enum logic [2:0] {
      CIST_T_ONCHIP_MEM,
      CIST_T_SUP_8BIT,
      CIST_T_SUP_16BIT,
      CIST_T_EXT8_2ST,
      CIST_T_EXT8_3ST,
      CIST_T_EXT16_2ST,
      CIST_T_EXT16_3ST
   } cist_tgt_t;

   // instruction forms covered
   typedef enum logic [4:0] {
      CIST_I_ADD_B_IMM,
      CIST_I_ADD_B_REG,
      CIST_I_ADD_W_IMM,
      CIST_I_ADD_W_REG,
      CIST_I_ADD_L_IMM,
      CIST_I_ADD_L_REG,
      CIST_I_ADD_SMALL_CONSTANT,
      CIST_I_ADD_WITH_CARRY_IMM,
      CIST_I_ADD_WITH_CARRY_REG,
      CIST_I_AND_B_IMM,
      CIST_I_AND_B_REG,
      CIST_I_AND_W_IMM,
      CIST_I_AND_W_REG,
      CIST_I_AND_L_IMM,
      CIST_I_AND_L_REG,
      CIST_I_AND_TO_CONDITION_CODES,
      CIST_I_BIT_AND_CARRY_REG,
      CIST_I_BIT_AND_CARRY_IND,
      CIST_I_BIT_AND_CARRY_ABS8,
      CIST_I_BRANCH_COND_D8
   } cist_instr_t;

   // state lengths per cycle
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_ONCHIP = 6'h02;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_F_SUP8 = 6'h06;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_F_SUP16 = 6'h03;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_F_EXT8_2 = 6'h04;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_F_EXT8_3 = 6'h06;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_F_EXT16_2 = 6'h02;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_F_EXT16_3 = 6'h03;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_B_SUP = 6'h03;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_B_EXT_2 = 6'h02;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_B_EXT_3 = 6'h03;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_W_SUP8 = 6'h06;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_W_EXT8_2 = 6'h04;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_W_EXT8_3 = 6'h06;
   localparam logic [CIST_LEN_W-1:0] CIST_LEN_INTERNAL = 6'h01;

   // cycle counts for one instruction, indexed by cycle kind
   typedef logic [CIST_KINDS-1:0][CIST_CNT_W-1:0] cist_counts_t;

   // access configuration of one instruction
   typedef struct packed {
      cist_tgt_t fetch_tgt;
      cist_tgt_t data_tgt;
      cist_tgt_t stack_tgt;
      logic [CIST_WAIT_W-1:0] wait_m;
   } cist_cfg_t;

   // reset values
   localparam logic [CIST_TOT_W-1:0] CIST_TOT_RST = 10'h000;

endpackage : cist_pkg

// *** logic/cist_len.sv ***
`timescale 1ns/10ps
`default_nettype none

module cist_len (
   input wire cist_pkg::cist_kind_t kind,
   input wire cist_pkg::cist_tgt_t tgt,
   input wire logic [cist_pkg::CIST_WAIT_W-1:0] wait_m,
   output logic [cist_pkg::CIST_LEN_W-1:0] len
);
   import cist_pkg::*;

   logic [CIST_LEN_W-1:0] m1;
   logic [CIST_LEN_W-1:0] m2;

   // wait states, once and doubled for 8-bit two-access cycles
   assign m1 = {2'h0, wait_m};
   assign m2 = {1'h0, wait_m, 1'b0};

   ////////////////////////////////////////////////////////////////////////
   // one lookup per kind and target
   always_comb begin
      len = CIST_LEN_ONCHIP;
      case (kind)
         CIST_K_INTERNAL: len = CIST_LEN_INTERNAL;
         CIST_K_FETCH: begin
            case (tgt)
               CIST_T_ONCHIP_MEM: len = CIST_LEN_ONCHIP;
               CIST_T_SUP_8BIT: len = CIST_LEN_F_SUP8;
               CIST_T_SUP_16BIT: len = CIST_LEN_F_SUP16;
               CIST_T_EXT8_2ST: len = CIST_LEN_F_EXT8_2;
               CIST_T_EXT8_3ST: len = CIST_LEN_F_EXT8_3 + m2;
               CIST_T_EXT16_2ST: len = CIST_LEN_F_EXT16_2;
               CIST_T_EXT16_3ST: len = CIST_LEN_F_EXT16_3 + m1;
               default: len = CIST_LEN_ONCHIP;
            endcase
         end
         CIST_K_BYTE: begin
            // a byte goes in one access whatever the bus width
            case (tgt)
               CIST_T_ONCHIP_MEM: len = CIST_LEN_ONCHIP;
               CIST_T_SUP_8BIT: len = CIST_LEN_B_SUP;
               CIST_T_SUP_16BIT: len = CIST_LEN_B_SUP;
               CIST_T_EXT8_2ST: len = CIST_LEN_B_EXT_2;
               CIST_T_EXT8_3ST: len = CIST_LEN_B_EXT_3 + m1;
               CIST_T_EXT16_2ST: len = CIST_LEN_B_EXT_2;
               CIST_T_EXT16_3ST: len = CIST_LEN_B_EXT_3 + m1;
               default: len = CIST_LEN_ONCHIP;
            endcase
         end
         default: begin
            // word, branch address and stack share word timing
            case (tgt)
               CIST_T_ONCHIP_MEM: len = CIST_LEN_ONCHIP;
               CIST_T_SUP_8BIT: len = CIST_LEN_W_SUP8;
               CIST_T_SUP_16BIT: len = CIST_LEN_F_SUP16;
               CIST_T_EXT8_2ST: len = CIST_LEN_W_EXT8_2;
               CIST_T_EXT8_3ST: len = CIST_LEN_W_EXT8_3 + m2;
               CIST_T_EXT16_2ST: len = CIST_LEN_F_EXT16_2;
               CIST_T_EXT16_3ST: len = CIST_LEN_F_EXT16_3 + m1;
               default: len = CIST_LEN_ONCHIP;
            endcase
         end
      endcase
   end

endmodule : cist_len

`default_nettype wire

// *** tb/cist_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cist_far_model (
   input wire cist_pkg::cist_tgt_t fetch_sel,
   input wire cist_pkg::cist_tgt_t data_sel,
   input wire logic [cist_pkg::CIST_WAIT_W-1:0] wait_sel,
   output cist_pkg::cist_cfg_t cfg
);
   import cist_pkg::*;
   // stack parked on a fast 16-bit bus; no covered form touches it
   assign cfg = '{fetch_tgt: fetch_sel, data_tgt: data_sel, stack_tgt: CIST_T_EXT16_2ST, wait_m: wait_sel};
endmodule : cist_far_model
`default_nettype wire

// *** tb/cist_timing_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module cist_timing_checker (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic start,
   input wire cist_pkg::cist_instr_t instr,
   input wire cist_pkg::cist_cfg_t cfg,
   input wire logic ready,
   input wire logic busy,
   input wire logic done,
   input wire logic cycle_start,
   input wire cist_pkg::cist_kind_t cur_kind,
   input wire logic [cist_pkg::CIST_TOT_W-1:0] total_states,
   input wire logic [cist_pkg::CIST_TOT_W-1:0] elapsed_states
);
   import cist_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // first state of a run, always a fetch
   sequence s_first;
      busy && cycle_start && cur_kind == CIST_K_FETCH && elapsed_states == 10'h000;
   endsequence
   sequence s_end;
      !busy && elapsed_states == total_states ##1 !done;
   endsequence
   ready_is_idle_a: assert property (ready == !busy) else $error("ready while busy");
   run_opens_fetch_a: assert property (start && ready |=> s_first) else $error("bad run start");
   state_tick_a: assert property (busy |=> elapsed_states == $past(elapsed_states) + 10'h001)
      else $error("state count slipped");
   total_held_a: assert property (!(start && ready) |=> $stable(total_states)) else $error("total moved");
   done_at_total_a: assert property (done |-> s_end) else $error("done off total");
   end_gives_done_a: assert property ($fell(busy) && $past(resetn) |-> done) else $error("no done");
   kind_order_a: assert property (busy && $past(busy) |-> cur_kind >= $past(cur_kind))
      else $error("kind order broken");
   branch_four_a: assert property (start && ready && instr == CIST_I_BRANCH_COND_D8
      && cfg.fetch_tgt == CIST_T_ONCHIP_MEM |=> total_states == 10'h004) else $error("branch total");
   cycle_in_run_a: assert property (cycle_start |-> busy) else $error("cycle start idle");
endmodule : cist_timing_checker
bind cist_timing cist_timing_checker u_cist_timing_checker (.clk_sys, .resetn, .start, .instr, .cfg,
   .ready, .busy, .done, .cycle_start, .cur_kind, .total_states, .elapsed_states);
`default_nettype wire

// *** tb/cpu_instruction_state_timing_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpu_instruction_state_timing_tb;
   import cist_pkg::*;
   logic clk_sys, resetn, start, ready, busy, done, cycle_start;
   cist_instr_t instr;
   cist_tgt_t fsel, dsel;
   logic [3:0] wsel;
   cist_cfg_t cfg;
   cist_kind_t cur_kind;
   logic [9:0] total_states, elapsed_states;
   int n_errors, samples_checked, cyc;
   int fc[20] = '{1, 1, 2, 1, 3, 1, 1, 1, 1, 1, 1, 2, 1, 3, 2, 1, 1, 2, 2, 2};
   cist_far_model u_cist_far_model (.fetch_sel(fsel), .data_sel(dsel), .wait_sel(wsel), .cfg(cfg));
   cist_timing u_cist_timing (.clk_sys(clk_sys), .resetn(resetn), .start(start), .instr(instr),
      .cfg(cfg), .ready(ready), .busy(busy), .done(done), .cycle_start(cycle_start),
      .cur_kind(cur_kind), .total_states(total_states), .elapsed_states(elapsed_states));
   ////////////////////////////////////////
   // clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         finish_test();
      end
   end
   ////////////////////////////////////////
   task finish_test();
      if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task check(input logic [9:0] got, input logic [9:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // expected lengths per cycle, worked out independently
   function automatic logic [9:0] flen(input cist_tgt_t t, input logic [3:0] m);
      case (t)
         CIST_T_SUP_8BIT: flen = 10'h006;
         CIST_T_SUP_16BIT: flen = 10'h003;
         CIST_T_EXT8_2ST: flen = 10'h004;
         CIST_T_EXT8_3ST: flen = 10'h006 + 10'(m) * 10'h002;
         CIST_T_EXT16_3ST: flen = 10'h003 + 10'(m);
         default: flen = 10'h002;
      endcase
   endfunction : flen
   function automatic logic [9:0] blen(input cist_tgt_t t, input logic [3:0] m);
      case (t)
         CIST_T_SUP_8BIT, CIST_T_SUP_16BIT: blen = 10'h003;
         CIST_T_EXT8_3ST, CIST_T_EXT16_3ST: blen = 10'h003 + 10'(m);
         default: blen = 10'h002;
      endcase
   endfunction : blen
   // one run; entered and left at a falling edge, so runs chain back to back
   task run(input cist_instr_t i, input logic [9:0] e, input logic [9:0] ncs);
      int n;
      int k;
      start = 1'b1;
      instr = i;
      @(negedge clk_sys);
      start = 1'b0;
      n = 0;
      k = 0;
      check(total_states, e);
      while (done !== 1'b1 && n < 500) begin
         n++;
         k += int'(cycle_start);
         @(negedge clk_sys);
      end
      check(10'(n), e);
      check(elapsed_states, e);
      check(10'(k), ncs);
   endtask : run
   ////////////////////////////////////////
   task t_fetch();
      dsel = CIST_T_ONCHIP_MEM;
      for (int t = 0; t < 7; t++) begin
         fsel = cist_tgt_t'(t);
         wsel = 4'h5;
         run(CIST_I_BRANCH_COND_D8, 10'h002 * flen(fsel, wsel), 10'h002);
      end
      fsel = CIST_T_EXT8_3ST;
      wsel = 4'hf;
      run(CIST_I_ADD_L_IMM, 10'h003 * flen(fsel, wsel), 10'h003);
   endtask : t_fetch
   task t_forms();
      logic b;
      fsel = CIST_T_SUP_16BIT;
      dsel = CIST_T_EXT8_3ST;
      wsel = 4'h2;
      for (int i = 0; i < 20; i++) begin
         b = (i == 17 || i == 18);
         run(cist_instr_t'(i), 10'(fc[i]) * 10'h003 + (b ? blen(dsel, wsel) : 10'h000),
            10'(fc[i]) + 10'(b));
      end
   endtask : t_forms
   task t_byte();
      fsel = CIST_T_ONCHIP_MEM;
      for (int t = 0; t < 7; t++) begin
         dsel = cist_tgt_t'(t);
         wsel = 4'h3;
         run(CIST_I_BIT_AND_CARRY_ABS8, 10'h004 + blen(dsel, wsel), 10'h003);
         check(10'(cur_kind), 10'(CIST_K_BYTE));
      end
   endtask : t_byte
   // a second start while counting must be ignored
   task t_refuse();
      int n;
      fsel = CIST_T_SUP_8BIT;
      start = 1'b1;
      instr = CIST_I_ADD_L_IMM;
      @(negedge clk_sys);
      instr = CIST_I_BRANCH_COND_D8;
      fsel = CIST_T_ONCHIP_MEM;
      @(negedge clk_sys);
      start = 1'b0;
      check(total_states, 10'h012);
      n = 0;
      while (done !== 1'b1 && n < 100) begin
         n++;
         @(negedge clk_sys);
      end
      check(elapsed_states, 10'h012);
   endtask : t_refuse
   // reset in mid-run clears the count
   task t_reset();
      start = 1'b1;
      instr = CIST_I_ADD_L_IMM;
      @(negedge clk_sys);
      start = 1'b0;
      repeat (3) @(negedge clk_sys);
      resetn = 1'b0;
      @(negedge clk_sys);
      resetn = 1'b1;
      check(10'(busy), 10'h000);
      check(10'(ready), 10'h001);
      check(total_states, 10'h000);
      run(CIST_I_AND_L_REG, 10'h004, 10'h002);
   endtask : t_reset
   ////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      start = 1'b0;
      instr = CIST_I_ADD_B_IMM;
      fsel = CIST_T_ONCHIP_MEM;
      dsel = CIST_T_ONCHIP_MEM;
      wsel = 4'h0;
      repeat (8) @(negedge clk_sys);
      resetn = 1'b1;
      t_fetch();
      t_forms();
      t_byte();
      t_refuse();
      t_reset();
      finish_test();
   end
endmodule : cpu_instruction_state_timing_tb
`default_nettype wire
